/* design/cps_card.sv */
/*
  Card end: command receiver, status word and responder, power state
  (active, auto sleep, inactive), write block receiver with CRC16 check and
  margin verify. Assumes the host makes the link clock well below core/6.
*/
module cps_card import cps_pkg::*; #(
  parameter int unsigned SLEEP_CYCLES = SLEEP_CYC
) (
  input  logic        core_clk_i,                     // core clock
  input  logic        rst_i,                          // sync reset, high
  cps_link_if.card    bus,                            // link to host
  input  logic        defect_i,                       // read-back found a bad bit
  output logic        sleep_o,                        // card sleeping
  output logic        inactive_o,                     // card inactive
  output logic [3:0]  state_o,                        // present card state
  output logic [1:0]  bus_width_o,                    // lane width code
  output logic [22:0] wr_addr_o,                      // sector being written
  output logic [7:0]  wr_data_o,                      // written byte
  output logic        wr_valid_o,                     // written byte strobe
  output logic        verify_o,                       // margin read-back start
  output logic        remap_o,                        // sector moved to spare
  output logic [7:0]  remap_count_o,                  // spares used so far
  output logic [31:0] card_specific_data_register_o   // block and group sizes
);
  cps_card_state_type state, next_state;
  logic [1:0]  lclk_s, cmd_s;
  logic [7:0]  dat_m, dat_s;
  logic        lclk_d;
  logic        cmd_busy, cmd_valid;
  logic [5:0]  cmd_cnt, rsp_cnt;
  logic [37:0] cmd_sr;
  logic [38:0] rsp_sr;
  logic        rsp_busy, rsp_q;
  logic [31:0] err;
  logic [1:0]  width;
  logic [9:0]  blklen;
  logic        multi, noerase;
  logic        d_busy;
  logic [3:0]  d_bits;
  logic [9:0]  d_bytes;
  logic [7:0]  d_sr;
  logic [15:0] d_crc, d_got;
  logic [4:0]  ver_cnt;
  logic [17:0] idle_cnt;

  // two-flop sampling of every link line; only the second stage is read
  always_ff @(posedge core_clk_i) begin
    lclk_s <= {lclk_s[0], bus.lclk};
    cmd_s  <= {cmd_s[0], bus.cmd};
    dat_m  <= bus.dat;
    dat_s  <= dat_m;
    lclk_d <= rst_i ? 1'b0 : lclk_s[1];
  end
  wire rise = lclk_s[1] & ~lclk_d;

  // command receiver
  wire cmd_start = rise & ~cmd_busy & ~cmd_s[1];
  wire cmd_done  = rise & cmd_busy & (cmd_cnt == FRAME_BITS - 6'h1);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_busy <= 1'b0;
      cmd_cnt  <= 6'h00;
      cmd_sr   <= '0;
    end else if (cmd_start) begin
      cmd_busy <= 1'b1;
      cmd_cnt  <= 6'h00;
    end else if (rise & cmd_busy) begin
      cmd_sr   <= {cmd_sr[36:0], cmd_s[1]};
      cmd_cnt  <= cmd_cnt + 6'h1;
      cmd_busy <= ~cmd_done;
    end
    cmd_valid <= ~rst_i & cmd_done;
  end

  // command decode
  wire [5:0]  idx     = cmd_sr[37:32];
  wire [31:0] arg     = cmd_sr[31:0];
  wire        take    = cmd_valid & (state != CS_INA);
  wire        in_tran = state == CS_TRAN;
  wire        in_wr   = (state == CS_RCV) | (state == CS_PRG);
  wire        is_wr   = (idx == CMD_WR_ONE) | (idx == CMD_WR_MULTI) | (idx == CMD_WR_NOERASE);
  wire        op_cond = (state == CS_IDLE) & (idx == CMD_OP_COND);
  wire        ocr_bad = (arg[23:0] & CARD_OCR) == 24'h000000;
  wire        illegal = ~((idx == CMD_STATUS) | (idx == CMD_GO_IDLE) | (idx == CMD_INACTIVE)
                        | op_cond | (in_wr & (idx == CMD_STOP))
                        | (in_tran & (is_wr | (idx == CMD_BUS_WIDTH) | (idx == CMD_BLOCKLEN))));
  wire        len_bad = (idx == CMD_BLOCKLEN) & ((arg == 32'h0) | (arg > 32'(SECTOR_BYTES)));
  wire        wr_len  = is_wr & (blklen != SECTOR_BYTES);
  wire        adr_bad = is_wr & (arg[8:0] != 9'h000);
  wire        w_bad   = (idx == CMD_BUS_WIDTH) & (arg[1:0] == 2'h3);
  wire [31:0] new_err = illegal ? (32'h1 << ST_ILLEGAL)
                      : ((32'(len_bad | wr_len) << ST_BLKLEN_ERR)
                      |  (32'(adr_bad) << ST_ADDR_ERR) | (32'(w_bad) << ST_WIDTH_ERR));
  wire        cmd_ok  = new_err == 32'h0;
  wire        silent  = (idx == CMD_INACTIVE) | (idx == CMD_GO_IDLE) | (op_cond & ocr_bad);
  wire        rsp_load = take & ~silent;
  wire [31:0] status_w = err | new_err | (32'(state) << ST_STATE_LSB)
                       | (32'(state != CS_PRG) << ST_READY_DATA);

  // data block receiver
  wire [3:0] d_next    = d_bits + lane_step(width);
  wire [7:0] d_byte    = lanes_in(d_sr, dat_s, width);
  wire       d_start   = rise & (state == CS_RCV) & ~d_busy & ~dat_s[0];
  wire       byte_done = rise & d_busy & (d_next == 4'h8);
  wire       is_data   = d_bytes < blklen;
  wire       last_byte = d_bytes == blklen + 10'h1;
  wire       blk_done  = byte_done & last_byte;
  wire       crc_bad   = {d_got[7:0], d_byte} != d_crc;
  wire       ver_done  = (state == CS_PRG) & (noerase | (ver_cnt == VERIFY_CYC));

  always_ff @(posedge core_clk_i) begin
    if (rst_i | (state != CS_RCV)) begin
      d_busy  <= 1'b0;
      d_bits  <= 4'h0;
      d_bytes <= 10'h000;
    end else if (d_start) begin
      d_busy  <= 1'b1;
      d_bits  <= 4'h0;
      d_bytes <= 10'h000;
      d_crc   <= 16'h0000;
    end else if (rise & d_busy) begin
      d_sr   <= d_byte;
      d_bits <= byte_done ? 4'h0 : d_next;
      if (byte_done) begin
        d_bytes <= d_bytes + 10'h1;
        d_busy  <= ~last_byte;
        if (is_data) begin
          d_crc <= crc16_byte(d_crc, d_byte);
        end else begin
          d_got <= {d_got[7:0], d_byte};
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      CS_IDLE: if (take & op_cond) next_state = ocr_bad ? CS_INA : CS_TRAN;
      CS_TRAN: if (take & is_wr & cmd_ok) next_state = CS_RCV;
      CS_RCV: begin
        if (blk_done) next_state = CS_PRG;
        else if (take & (idx == CMD_STOP)) next_state = CS_TRAN;
      end
      CS_PRG: if (ver_done) next_state = multi ? CS_RCV : CS_TRAN;
      CS_INA: next_state = CS_INA;
      default: next_state = CS_IDLE;
    endcase
    if (take & (idx == CMD_GO_IDLE)) next_state = CS_IDLE;
    if (take & (idx == CMD_INACTIVE)) next_state = CS_INA;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state   <= CS_IDLE;
      width   <= W1;
      blklen  <= SECTOR_BYTES;
      multi   <= 1'b0;
      noerase <= 1'b0;
      ver_cnt <= 5'h00;
      err     <= 32'h0;
      wr_addr_o <= 23'h0;
    end else begin
      state   <= next_state;
      ver_cnt <= (state == CS_PRG) ? ver_cnt + 5'h1 : 5'h00;
      // completion codes clear once reported; a crc error in that cycle still lands
      err <= (take ? 32'h0 : err) | (32'(blk_done & crc_bad) << ST_CRC_ERR);
      if (take & in_tran & cmd_ok) begin
        if (idx == CMD_BUS_WIDTH) width <= arg[1:0];
        if (idx == CMD_BLOCKLEN) blklen <= arg[9:0];
        if (is_wr) begin
          multi     <= idx == CMD_WR_MULTI;
          noerase   <= idx == CMD_WR_NOERASE;
          wr_addr_o <= arg[31:9];
        end
      end
      if (take & in_wr & (idx == CMD_STOP)) multi <= 1'b0;
      if (ver_done) wr_addr_o <= wr_addr_o + 23'h1;
    end
  end

  // responder
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rsp_busy <= 1'b0;
      rsp_cnt  <= 6'h00;
      rsp_q    <= 1'b1;
    end else if (rsp_load) begin
      rsp_sr   <= {1'b0, idx, status_w};
      rsp_busy <= 1'b1;
      rsp_cnt  <= 6'h00;
    end else if (rise) begin
      rsp_q <= rsp_busy ? rsp_sr[38] : 1'b1;
      if (rsp_busy) begin
        rsp_sr   <= {rsp_sr[37:0], 1'b1};
        rsp_cnt  <= rsp_cnt + 6'h1;
        rsp_busy <= rsp_cnt != FRAME_BITS;
      end
    end
  end
  assign bus.rsp = rsp_q;
  wire rsp_done = rise & rsp_busy & (rsp_cnt == FRAME_BITS);

  // automatic sleep
  wire quiet = ((state == CS_IDLE) | (state == CS_TRAN)) & ~cmd_busy & ~rsp_busy;
  wire kick  = cmd_start | cmd_valid | rsp_done | ver_done;
  always_ff @(posedge core_clk_i) begin
    if (rst_i | kick | ~quiet) begin
      idle_cnt <= 18'h00000;
    end else if (idle_cnt != 18'(SLEEP_CYCLES)) begin
      idle_cnt <= idle_cnt + 18'h1;
    end
    sleep_o <= ~rst_i & ~kick & (idle_cnt == 18'(SLEEP_CYCLES));
  end

  // back end strobes and published sizes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_valid_o    <= 1'b0;
      wr_data_o     <= 8'h00;
      verify_o      <= 1'b0;
      remap_o       <= 1'b0;
      remap_count_o <= 8'h00;
      card_specific_data_register_o <= CSD_RESET;
    end else begin
      wr_valid_o <= byte_done & is_data;
      if (byte_done & is_data) wr_data_o <= d_byte;
      verify_o <= blk_done & ~noerase;
      remap_o  <= ver_done & ~noerase & defect_i;
      if (ver_done & ~noerase & defect_i) remap_count_o <= remap_count_o + 8'h1;
    end
  end

  assign inactive_o  = state == CS_INA;
  assign state_o     = state;
  assign bus_width_o = width;
endmodule

/* design/cps_host.sv */
/*
  Host end: makes the link clock by a divider, sends commands, collects
  responses or times out, tracks bus width and block length, and streams
  write blocks with CRC16. Assumes the user keeps bytes valid through a block.
*/
module cps_host import cps_pkg::*; (
  input  logic        core_clk_i,     // core clock
  input  logic        rst_i,          // sync reset, high
  cps_link_if.host    bus,            // link to card
  input  logic        req_valid_i,    // command request
  input  logic [5:0]  req_idx_i,      // command code
  input  logic [31:0] req_arg_i,      // command argument
  output logic        req_ready_o,    // host idle, ready for a request
  output logic        resp_valid_o,   // response received pulse
  output logic [31:0] resp_status_o,  // received status word
  output logic        resp_timeout_o, // no response pulse
  input  logic [7:0]  wbyte_i,        // write data byte
  input  logic        wbyte_valid_i,  // write byte offered
  output logic        wbyte_ready_o,  // write byte consumed
  output logic        blk_done_o      // block sent pulse
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_CMD   = 3'h1,
    H_WAIT  = 3'h2,
    H_RESP  = 3'h3,
    H_START = 3'h4,
    H_DATA  = 3'h5,
    H_GAP   = 3'h6
  } cps_host_state_type;
  cps_host_state_type hs;
  logic [2:0]  div;
  logic        lclk_q, cmd_q;
  logic [7:0]  dat_q, hb;
  logic [1:0]  rsp_s;
  logic [38:0] hsr;
  logic [5:0]  cnt, r_idx;
  logic [31:0] r_arg;
  logic [1:0]  width;
  logic [9:0]  blen, bcnt;
  logic [3:0]  hbits;
  logic [15:0] crc;
  logic        multi;

  wire tick   = div == LCLK_HALF - 3'h1;
  wire h_rise = tick & ~lclk_q;
  wire h_fall = tick & lclk_q;
  wire [31:0] stat   = {hsr[30:0], rsp_s[1]};
  wire        ok     = (stat & ERR_MASK) == 32'h0;
  wire        r_wr   = (r_idx == CMD_WR_ONE) | (r_idx == CMD_WR_MULTI) | (r_idx == CMD_WR_NOERASE);
  wire        resp_end = (hs == H_RESP) & h_rise & (cnt == FRAME_BITS - 6'h1);
  wire [7:0]  src    = (bcnt < blen) ? wbyte_i : ((bcnt == blen) ? crc[15:8] : crc[7:0]);
  wire [7:0]  cur    = (hbits == 4'h0) ? src : hb;
  wire [3:0]  h_next = hbits + lane_step(width);
  wire        load   = (hs == H_DATA) & h_fall & (hbits == 4'h0);

  assign req_ready_o   = hs == H_IDLE;
  assign wbyte_ready_o = load & (bcnt < blen);
  assign bus.lclk = lclk_q;
  assign bus.cmd  = cmd_q;
  assign bus.dat  = dat_q;

  always_ff @(posedge core_clk_i) begin
    rsp_s <= {rsp_s[0], bus.rsp};
    if (rst_i) begin
      div    <= 3'h0;
      lclk_q <= 1'b0;
    end else begin
      div <= tick ? 3'h0 : div + 3'h1;
      if (tick) lclk_q <= ~lclk_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hs <= H_IDLE;
      cmd_q <= 1'b1;
      dat_q <= 8'hff;
      cnt <= 6'h00;
      width <= W1;
      blen <= SECTOR_BYTES;
      multi <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_timeout_o <= 1'b0;
      resp_status_o <= 32'h0;
      blk_done_o <= 1'b0;
    end else begin
      resp_valid_o <= resp_end;
      resp_timeout_o <= 1'b0;
      blk_done_o <= 1'b0;
      case (hs)
        H_IDLE: begin
          if (req_valid_i) begin
            hsr   <= {1'b0, req_idx_i, req_arg_i};
            r_idx <= req_idx_i;
            r_arg <= req_arg_i;
            cnt   <= 6'h00;
            hs    <= H_CMD;
          end else if (multi & wbyte_valid_i) begin
            hs <= H_START;
          end
        end
        H_CMD: if (h_fall) begin
          cmd_q <= hsr[38];
          hsr   <= {hsr[37:0], 1'b1};
          cnt   <= cnt + 6'h1;
          if (cnt == FRAME_BITS) begin
            cnt <= 6'h00;
            hs  <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (h_fall) cmd_q <= 1'b1;
          if (h_rise) begin
            cnt <= cnt + 6'h1;
            if (~rsp_s[1]) begin
              cnt <= 6'h00;
              hs  <= H_RESP;
            end else if (cnt == RSP_WAIT) begin
              resp_timeout_o <= 1'b1;
              hs <= H_IDLE;
            end
          end
        end
        H_RESP: if (h_rise) begin
          hsr <= {hsr[37:0], rsp_s[1]};
          cnt <= cnt + 6'h1;
          if (resp_end) begin
            resp_status_o <= stat;
            hs <= (r_wr & ok) ? H_START : H_IDLE;
            if (ok & (r_idx == CMD_BUS_WIDTH)) width <= r_arg[1:0];
            if (ok & (r_idx == CMD_BLOCKLEN)) blen <= r_arg[9:0];
            if (ok & r_wr) multi <= r_idx == CMD_WR_MULTI;
            if (r_idx == CMD_STOP) multi <= 1'b0;
          end
        end
        H_START: if (h_fall) begin
          dat_q <= 8'h00;
          crc   <= 16'h0000;
          bcnt  <= 10'h000;
          hbits <= 4'h0;
          hs    <= H_DATA;
        end
        H_DATA: if (h_fall) begin
          dat_q <= lanes_out(cur, width);
          hb    <= shift_out(cur, width);
          hbits <= (h_next == 4'h8) ? 4'h0 : h_next;
          if (load & (bcnt < blen)) crc <= crc16_byte(crc, src);
          if (h_next == 4'h8) begin
            bcnt <= bcnt + 10'h1;
            if (bcnt == blen + 10'h1) begin
              cnt <= 6'h00;
              hs  <= H_GAP;
            end
          end
        end
        H_GAP: if (h_fall) begin
          dat_q <= 8'hff;
          cnt   <= cnt + 6'h1;
          if (cnt == 6'(GAP_FALLS)) begin
            blk_done_o <= 1'b1;
            hs <= H_IDLE;
          end
        end
        default: hs <= H_IDLE;
      endcase
    end
  end
endmodule

/* design/cps_link_if.sv */
/*
  Link between host and card: host-made link clock, command line,
  response line and eight write data lanes. All lines but the link clock idle high; the clock is low in reset.
*/
interface cps_link_if;
  logic       lclk;
  logic       cmd;
  logic       rsp;
  logic [7:0] dat;
  modport host (output lclk, output cmd, output dat, input rsp);
  modport card (input lclk, input cmd, input dat, output rsp);
endinterface

/* design/cps_pkg.sv */
/*
  Shared constants, types and helper functions for the card power/state/status
  link: command codes, status layout, timing counts, lane packing and CRC16.
  Assumes a single 50 MHz core clock on both ends of the link.
*/
package cps_pkg;
  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned SLEEP_MS  = 5;
  localparam int unsigned SLEEP_CYC = SLEEP_MS * (CLK_HZ / 1000);
  localparam logic [2:0]  LCLK_HALF = 3'h4;   // core cycles per link clock half period
  localparam logic [5:0]  FRAME_BITS = 6'h26; // bits after the start bit in cmd and rsp
  localparam logic [5:0]  RSP_WAIT  = 6'h3f;  // link rises before a missing answer times out
  localparam logic [3:0]  GAP_FALLS = 4'h8;   // host idle falls after each data block
  localparam logic [4:0]  VERIFY_CYC = 5'h10; // margin read-back time in core cycles

  localparam logic [5:0] CMD_GO_IDLE    = 6'h00;
  localparam logic [5:0] CMD_OP_COND    = 6'h01;
  localparam logic [5:0] CMD_BUS_WIDTH  = 6'h06;
  localparam logic [5:0] CMD_STOP       = 6'h0c;
  localparam logic [5:0] CMD_STATUS     = 6'h0d;
  localparam logic [5:0] CMD_INACTIVE   = 6'h0f;
  localparam logic [5:0] CMD_BLOCKLEN   = 6'h10;
  localparam logic [5:0] CMD_WR_ONE     = 6'h18;
  localparam logic [5:0] CMD_WR_MULTI   = 6'h19;
  localparam logic [5:0] CMD_WR_NOERASE = 6'h1a;

  localparam logic [9:0]  SECTOR_BYTES = 10'h200;
  localparam logic [23:0] CARD_OCR     = 24'hff8000; // supported voltage window
  localparam logic [1:0]  W1 = 2'h0;
  localparam logic [1:0]  W4 = 2'h1;
  localparam logic [1:0]  W8 = 2'h2;

  localparam int unsigned ST_ADDR_ERR   = 30;
  localparam int unsigned ST_BLKLEN_ERR = 29;
  localparam int unsigned ST_CRC_ERR    = 23;
  localparam int unsigned ST_ILLEGAL    = 22;
  localparam int unsigned ST_WIDTH_ERR  = 19;
  localparam int unsigned ST_STATE_LSB  = 9;
  localparam int unsigned ST_READY_DATA = 8;
  localparam logic [31:0] ERR_MASK      = 32'h60c80000;

  localparam logic [7:0] CSD_BLK_PROG    = 8'h01; // block length programmable
  localparam logic [7:0] CSD_BLK_LOG2    = 8'h09; // write block 512 bytes
  localparam logic [7:0] CSD_ERASE_BLKS  = 8'h20; // write blocks per erase group
  localparam logic [7:0] CSD_WP_GROUPS   = 8'h08; // erase groups per protect group
  localparam logic [31:0] CSD_RESET = {CSD_BLK_PROG, CSD_BLK_LOG2, CSD_ERASE_BLKS, CSD_WP_GROUPS};

  typedef enum logic [3:0] {
    CS_IDLE = 4'h0,
    CS_TRAN = 4'h4,
    CS_RCV  = 4'h6,
    CS_PRG  = 4'h7,
    CS_INA  = 4'hf
  } cps_card_state_type;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return r;
  endfunction

  function automatic logic [3:0] lane_step(input logic [1:0] w);
    case (w)
      W4:      lane_step = 4'h4;
      W8:      lane_step = 4'h8;
      default: lane_step = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] lanes_in(input logic [7:0] b, input logic [7:0] d,
                                          input logic [1:0] w);
    case (w)
      W4:      lanes_in = {b[3:0], d[3:0]};
      W8:      lanes_in = d;
      default: lanes_in = {b[6:0], d[0]};
    endcase
  endfunction

  function automatic logic [7:0] lanes_out(input logic [7:0] b, input logic [1:0] w);
    case (w)
      W4:      lanes_out = {4'hf, b[7:4]};
      W8:      lanes_out = b;
      default: lanes_out = {7'h7f, b[7]};
    endcase
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] b, input logic [1:0] w);
    case (w)
      W4:      shift_out = {b[3:0], 4'h0};
      W8:      shift_out = 8'h00;
      default: shift_out = {b[6:0], 1'b0};
    endcase
  endfunction
endpackage

/* verification/cps_link_monitor.sv */
/*
  Link checks on the host-card lines, beside the shared interface.
  Assumes one core clock for both ends and a synchronous high reset.
*/
module cps_link_monitor (
  input wire logic       core_clk_i, // core clock
  input wire logic       rst_i,      // sync reset, high
  input wire logic       lclk_i,     // link clock
  input wire logic       cmd_i,      // command line
  input wire logic       rsp_i,      // response line
  input wire logic [7:0] dat_i       // write lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_idle;
    disable iff (1'b0) rst_i ##1 rst_i |-> rsp_i && cmd_i && dat_i == 8'hff && !lclk_i;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle in reset");
  property p_lclk_half;
    !$stable(lclk_i) |=> $stable(lclk_i) [*3];
  endproperty
  a_lclk_half: assert property (p_lclk_half) else $error("link clock half too short");
  property p_cmd_bit;
    !$stable(cmd_i) |=> $stable(cmd_i) [*7];
  endproperty
  a_cmd_bit: assert property (p_cmd_bit) else $error("command bit too short");
  property p_cmd_edge;
    !$stable(cmd_i) |-> !lclk_i;
  endproperty
  a_cmd_edge: assert property (p_cmd_edge) else $error("command moved while clock high");
  property p_rsp_bit;
    !$stable(rsp_i) |=> $stable(rsp_i) [*7];
  endproperty
  a_rsp_bit: assert property (p_rsp_bit) else $error("response bit too short");
  property p_dat_bit;
    !$stable(dat_i) |=> $stable(dat_i) [*7];
  endproperty
  a_dat_bit: assert property (p_dat_bit) else $error("data lanes held too short");
  property p_dat_edge;
    !$stable(dat_i) |-> !lclk_i;
  endproperty
  a_dat_edge: assert property (p_dat_edge) else $error("data moved while clock high");
  property p_one_cmd;
    $fell(cmd_i) |-> rsp_i;
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("command during response");
endmodule

/* verification/tb_top.sv */
/*
  Bench: host and card joined by the link; user sides driven here.
  Assumes the host answers each request by a response or a timeout.
*/
module tb_top import cps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, wbyte_valid = 1'b0;
  logic        defect = 1'b0, to;
  logic [5:0]  req_idx = 6'h00;
  logic [31:0] req_arg = 32'h0, resp_status, card_specific_data_register, st, e;
  logic [7:0]  wbyte = 8'h00, wr_data, remap_cnt;
  logic [22:0] wr_addr;
  logic [3:0]  state;
  logic [1:0]  width;
  logic        req_ready, resp_valid, resp_to, wbyte_ready, blk_done, sleep, inact;
  logic        wr_valid, verify, remap;
  int          err_total = 0, cmp_count = 0, seed = 11149, n_ver = 0, exp_rmp = 0, n_rmp = 0;
  int          feed_q[$], exp_q[$];
  logic [5:0]  ec[4] = '{CMD_BUS_WIDTH, CMD_BLOCKLEN, CMD_BLOCKLEN, CMD_STOP};
  logic [31:0] ea[4] = '{32'h3, 32'h0, 32'h201, 32'h0};
  int          eb[4] = '{ST_WIDTH_ERR, ST_BLKLEN_ERR, ST_BLKLEN_ERR, ST_ILLEGAL};

  initial forever #10 core_clk = ~core_clk;
  cps_link_if link ();
  cps_host i_cps_host (.core_clk_i(core_clk), .rst_i(rst), .bus(link.host),
    .req_valid_i(req_valid), .req_idx_i(req_idx), .req_arg_i(req_arg),
    .req_ready_o(req_ready), .resp_valid_o(resp_valid), .resp_status_o(resp_status),
    .resp_timeout_o(resp_to), .wbyte_i(wbyte), .wbyte_valid_i(wbyte_valid),
    .wbyte_ready_o(wbyte_ready), .blk_done_o(blk_done));
  cps_card #(.SLEEP_CYCLES(200)) i_cps_card (.core_clk_i(core_clk), .rst_i(rst),
    .bus(link.card), .defect_i(defect), .sleep_o(sleep), .inactive_o(inact),
    .state_o(state), .bus_width_o(width), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid), .verify_o(verify), .remap_o(remap),
    .remap_count_o(remap_cnt), .card_specific_data_register_o(card_specific_data_register));
  cps_link_monitor i_cps_link_monitor (.core_clk_i(core_clk), .rst_i(rst),
    .lclk_i(link.lclk), .cmd_i(link.cmd), .rsp_i(link.rsp), .dat_i(link.dat));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic send(input logic [5:0] i, input logic [31:0] a);
    int n;
    n = 0;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_idx = i;
    req_arg = a;
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    req_valid = 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (n < 3000 && resp_valid !== 1'b1 && resp_to !== 1'b1);
    to = resp_valid !== 1'b1;
    st = resp_status;
    // neither answer nor timeout: the host hung
    if (resp_valid !== 1'b1 && resp_to !== 1'b1) begin
      chk(resp_valid, 1'b1);
      report_and_stop;
    end
  endtask

  // bytes leave the queue as the host consumes them
  always @(posedge core_clk) begin
    if (wbyte_ready === 1'b1) void'(feed_q.pop_front());
    if (wr_valid === 1'b1) chk(wr_data, 32'(exp_q.pop_front()));
    if (verify === 1'b1) n_ver++;
    if (remap === 1'b1) n_rmp++;
  end
  always @(negedge core_clk) if (feed_q.size() > 0) wbyte <= 8'(feed_q[0]);

  task automatic wr(input logic [5:0] i, input int nb);
    logic [31:0] a;
    logic [1:0]  w;
    int          k;
    a = $random(seed) & 32'h0ffffe00;
    w = (i == CMD_WR_NOERASE) ? W1 : (($random(seed) & 1) ? W8 : W4);
    defect = 1'($random(seed));
    n_ver = 0;
    send(CMD_BUS_WIDTH, {30'h0, w});
    chk(width, w);
    repeat (nb * 512) begin
      k = $random(seed) & 8'hff;
      feed_q.push_back(k);
      exp_q.push_back(k);
    end
    wbyte_valid = 1'b1;
    send(i, a);
    chk(st & ERR_MASK, 32'h0);
    k = 0;
    for (int n = 0; n < 60000 && k < nb; n++) begin
      @(negedge core_clk);
      if (blk_done === 1'b1) k++;
    end
    wbyte_valid = 1'b0;
    send((i == CMD_WR_MULTI) ? CMD_STOP : CMD_STATUS, 32'h0);
    chk(st & ERR_MASK, 32'h0);
    repeat (60) @(negedge core_clk);
    exp_rmp += (defect && i != CMD_WR_NOERASE) ? nb : 0;
    chk(k, nb);
    chk(wr_addr, a[31:9] + nb);
    chk(n_ver, (i == CMD_WR_NOERASE) ? 0 : nb);
    chk(remap_cnt, exp_rmp);
    chk(n_rmp, exp_rmp);
    chk(exp_q.size(), 0);
    $display("test write %h done", i);
  endtask

  initial begin
    #1_800_000;
    err_total++;
    report_and_stop;
  end

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    chk(card_specific_data_register, 32'h01092008);
    chk(width, W1);
    send(CMD_OP_COND, 32'h00ff8000);
    send(CMD_STATUS, 32'h0);
    chk(st[12:9], CS_TRAN);
    for (int j = 0; j < 4; j++) begin
      send(ec[j], ea[j]);
      e = st;
      send(CMD_STATUS, 32'h0);
      chk((e | st) & ERR_MASK, 32'h1 << eb[j]);
    end
    chk(width, W1);
    send(CMD_BLOCKLEN, 32'h200);
    $display("test setup done");
    wr(CMD_WR_ONE, 1);
    wr(CMD_WR_NOERASE, 1);
    wr(CMD_WR_MULTI, 2);
    repeat (300) @(negedge core_clk);
    chk(sleep, 1'b1);
    send(CMD_STATUS, 32'h0);
    chk(to, 1'b0);
    repeat (150) @(negedge core_clk);
    chk(sleep, 1'b0);
    $display("test sleep done");
    send(CMD_INACTIVE, 32'h0);
    send(CMD_GO_IDLE, 32'h0);
    send(CMD_STATUS, 32'h0);
    chk(to, 1'b1);
    chk(inact, 1'b1);
    rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    chk(state, CS_IDLE);
    send(CMD_OP_COND, 32'h00000001);
    send(CMD_STATUS, 32'h0);
    chk(to, 1'b1);
    chk(inact, 1'b1);
    $display("test inactive done");
    report_and_stop;
  end
endmodule
